// *** hw/rivp_pkg.sv ***
// Contract
// - every reset source fetches vector one at program address zero unless relocated
// - enhanced stage capture, end cycle, end enhanced cycle use offsets 1, 2, 3
// - reduced stage capture, end cycle, end enhanced cycle use offsets 4, 5, 6
// - comparators zero, one, two use offsets 7, 8, 9
// - external requests zero, one, two use offsets 0xA, 0xE, 0x10
// - timer one capture 0xB, overflow 0xC, conversion complete 0xD
// - serial transfer complete uses offset 0xF
// - watchdog 0x11, nonvolatile data ready 0x12, self program ready 0x13
// - programmed boot fuse starts execution at the boot reset address
// - select bit set adds the boot section start to every vector offset
// - reset at zero or boot address; vectors from 1 or boot address plus 1
// - select changes only by enable then write within four cycles with enable zero
package rivp_pkg;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned NUM_SRC    = 19;
  localparam int unsigned CHG_WINDOW = 4;
  localparam logic [ADDR_W-1:0] RESET_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] BOOT_START   = 12'h0C00;
  localparam logic [3:0] CHG_COUNT = 4'h4;
  localparam logic [7:0] CORE_CTRL_RESET = 8'h00;
  localparam int unsigned SEL_BIT = 1;
  localparam int unsigned CHG_BIT = 0;

  // source index i owns vector offset i+1
  localparam logic [ADDR_W-1:0] VEC_OFFSET [NUM_SRC] = '{
    12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006, 12'h007,
    12'h008, 12'h009, 12'h00A, 12'h00B, 12'h00C, 12'h00D, 12'h00E,
    12'h00F, 12'h010, 12'h011, 12'h012, 12'h013};
  // source index zero is vector number two, right after the reset vector
  localparam logic [4:0] FIRST_VEC_NUM = 5'h02;

  typedef struct packed {
    logic self_program_ready;
    logic nvdata_ready;
    logic watchdog_timeout;
    logic external_request_two;
    logic serial_transfer_complete;
    logic external_request_one;
    logic conversion_complete;
    logic timer_one_overflow;
    logic timer_one_capture;
    logic external_request_zero;
    logic analog_comparator_two;
    logic analog_comparator_one;
    logic analog_comparator_zero;
    logic reduced_end_enh_cycle;
    logic reduced_end_cycle;
    logic reduced_capture;
    logic enhanced_end_enh_cycle;
    logic enhanced_end_cycle;
    logic enhanced_capture;
  } rivp_req_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [4:0]        number;
  } rivp_vec_t;

  typedef enum logic {RIVP_BOOT, RIVP_RUN} rivp_state_t;
endpackage

// *** hw/rivp_prio_enc.sv ***
`timescale 1ns/10ps
module rivp_prio_enc #(
  parameter int unsigned N = rivp_pkg::NUM_SRC
) (
  input  wire logic [N-1:0] req,
  output logic              hit,
  output logic [4:0]        idx
);
  initial
  begin
    if (N < 1 || N > 31)
    begin
      $error("rivp_prio_enc: N out of range");
    end
  end

  always_comb
  begin
    hit = 1'b0;
    idx = 5'h00;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        hit = 1'b1;
        idx = 5'(i);
      end
    end
  end
endmodule

// *** hw/rivp_top.sv ***
`timescale 1ns/10ps
module rivp_top #(
  parameter logic [rivp_pkg::ADDR_W-1:0] BOOT_RESET_ADDR = rivp_pkg::BOOT_START
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rstn,
  input  wire logic                            boot_reset_fuse,
  input  wire rivp_pkg::rivp_req_t             req,
  input  wire logic [rivp_pkg::NUM_SRC-1:0]    enable,
  input  wire logic                            global_enable,
  input  wire logic                            ctrl_wr,
  input  wire logic [7:0]                      ctrl_wdata,
  input  wire logic                            vec_ack,
  output logic [rivp_pkg::ADDR_W-1:0]          reset_addr,
  output rivp_pkg::rivp_vec_t                  vec,
  output logic                                 vector_table_select,
  output logic                                 vector_change_enable
);
  rivp_pkg::rivp_state_t         state_r;
  rivp_pkg::rivp_state_t         state_nxt;
  logic [rivp_pkg::ADDR_W-1:0]   reset_addr_r;
  logic [rivp_pkg::ADDR_W-1:0]   reset_addr_nxt;
  logic                          sel_r;
  logic                          sel_nxt;
  logic                          chg_r;
  logic                          chg_nxt;
  logic [3:0]                    chg_cnt_r;
  logic [3:0]                    chg_cnt_nxt;
  rivp_pkg::rivp_vec_t           vec_r;
  rivp_pkg::rivp_vec_t           vec_nxt;
  logic [rivp_pkg::NUM_SRC-1:0]  pending;
  logic                          hit;
  logic [4:0]                    idx;
  logic [rivp_pkg::ADDR_W-1:0]   base;

  initial
  begin
    if (rivp_pkg::CHG_COUNT != 4'(rivp_pkg::CHG_WINDOW))
    begin
      $error("rivp_top: change window and its count disagree");
    end
    // a boot table that wraps would alias the application table
    if (int'(BOOT_RESET_ADDR) + int'(rivp_pkg::VEC_OFFSET[rivp_pkg::NUM_SRC-1])
        >= (1 << rivp_pkg::ADDR_W))
    begin
      $error("rivp_top: boot vector table runs past the address space");
    end
  end

  assign pending = req & enable & {rivp_pkg::NUM_SRC{global_enable}};

  rivp_prio_enc #(
    .N(rivp_pkg::NUM_SRC)
  ) u_prio (
    .req (pending),
    .hit (hit),
    .idx (idx)
  );

  // fuse read once after reset release; 0 means programmed
  always_comb
  begin
    state_nxt      = state_r;
    reset_addr_nxt = reset_addr_r;
    if (state_r == rivp_pkg::RIVP_BOOT)
    begin
      state_nxt = rivp_pkg::RIVP_RUN;
      if (boot_reset_fuse)
      begin
        reset_addr_nxt = rivp_pkg::RESET_OFFSET;
      end
      else
      begin
        reset_addr_nxt = BOOT_RESET_ADDR;
      end
    end
  end

  // timed select change
  always_comb
  begin
    sel_nxt     = sel_r;
    chg_nxt     = chg_r;
    chg_cnt_nxt = chg_cnt_r;
    if (chg_cnt_r != 4'h0)
    begin
      chg_cnt_nxt = chg_cnt_r - 4'h1;
      if (chg_cnt_r == 4'h1)
      begin
        chg_nxt = 1'b0;
      end
    end
    if (ctrl_wr)
    begin
      if (ctrl_wdata[rivp_pkg::CHG_BIT])
      begin
        chg_nxt     = 1'b1;
        chg_cnt_nxt = rivp_pkg::CHG_COUNT;
      end
      else if (chg_r)
      begin
        sel_nxt     = ctrl_wdata[rivp_pkg::SEL_BIT];
        chg_nxt     = 1'b0;
        chg_cnt_nxt = 4'h0;
      end
    end
  end

  // vector dispatch, held until acknowledged
  always_comb
  begin
    vec_nxt = vec_r;
    base    = sel_r ? BOOT_RESET_ADDR : rivp_pkg::RESET_OFFSET;
    if (!vec_r.valid || vec_ack)
    begin
      vec_nxt.valid  = hit;
      vec_nxt.number = 5'(idx + rivp_pkg::FIRST_VEC_NUM);
      vec_nxt.addr   = base + rivp_pkg::VEC_OFFSET[idx];
      if (!hit)
      begin
        vec_nxt.addr   = '0;
        vec_nxt.number = 5'h00;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_r      <= rivp_pkg::RIVP_BOOT;
      reset_addr_r <= rivp_pkg::RESET_OFFSET;
    end
    else
    begin
      state_r      <= state_nxt;
      reset_addr_r <= reset_addr_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      sel_r     <= rivp_pkg::CORE_CTRL_RESET[rivp_pkg::SEL_BIT];
      chg_r     <= rivp_pkg::CORE_CTRL_RESET[rivp_pkg::CHG_BIT];
      chg_cnt_r <= 4'h0;
    end
    else
    begin
      sel_r     <= sel_nxt;
      chg_r     <= chg_nxt;
      chg_cnt_r <= chg_cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      vec_r <= '0;
    end
    else
    begin
      vec_r <= vec_nxt;
    end
  end

  assign reset_addr           = reset_addr_r;
  assign vec                  = vec_r;
  assign vector_table_select  = sel_r;
  assign vector_change_enable = chg_r;
endmodule

// *** test/reset_interrupt_vector_placement_bench.sv ***
`timescale 1ns/10ps
module reset_interrupt_vector_placement_bench;
  localparam logic [11:0] BRA = 12'h0C00;
  logic        sys_clk = 1'b0, rstn = 1'b0, boot_reset_fuse = 1'b1, global_enable = 1'b1;
  logic        ctrl_wr = 1'b0, vec_ack, vector_table_select, vector_change_enable;
  logic [1:0]  lag = 2'h0;
  logic [7:0]  ctrl_wdata = 8'h00;
  logic [11:0] reset_addr;
  logic [18:0] rq = 19'h0, enable = 19'h7_FFFF;
  int          fail_count = 0, checks = 0;
  rivp_pkg::rivp_req_t req;
  rivp_pkg::rivp_vec_t vec;
  assign req = rq;
  rivp_top #(
    .BOOT_RESET_ADDR(BRA)
  ) u_dut (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .boot_reset_fuse      (boot_reset_fuse),
    .req                  (req),
    .enable               (enable),
    .global_enable        (global_enable),
    .ctrl_wr              (ctrl_wr),
    .ctrl_wdata           (ctrl_wdata),
    .vec_ack              (vec_ack),
    .reset_addr           (reset_addr),
    .vec                  (vec),
    .vector_table_select  (vector_table_select),
    .vector_change_enable (vector_change_enable)
  );
  rivp_core_model u_core (.sys_clk(sys_clk), .rstn(rstn), .vec(vec), .lag(lag), .vec_ack(vec_ack));
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic rst(input logic f);
    rstn = 1'b0;
    boot_reset_fuse = f;
    cyc(5);
    rstn = 1'b1;
    cyc(2);
  endtask
  task automatic wrc(input logic [7:0] d);
    cyc(1);
    ctrl_wr = 1'b1;
    ctrl_wdata = d;
    cyc(1);
    ctrl_wr = 1'b0;
  endtask
  task automatic take(output logic [16:0] got);
    for (int n = 0; n < 40; n++)
    begin
      cyc(1);
      if (vec_ack === 1'b1)
      begin
        got = {vec.addr, vec.number};
        return;
      end
    end
    fail_count++;
    results();
  endtask
  task automatic s_reset;
    rst(1'b0);
    chk(reset_addr, BRA);
    rst(1'b1);
    chk(reset_addr, 12'h000);
  endtask
  task automatic s_table;
    logic [16:0] got;
    for (int i = 0; i < 19; i++)
    begin
      rq = 19'h1 << i;
      take(got);
      rq = 19'h0;
      chk(got, {12'(i+1), 5'(i+2)});
      cyc(2);
    end
  endtask
  task automatic s_prio;
    logic [16:0] got;
    int o[3] = '{5, 9, 18};
    lag = 2'h2;
    enable[0] = 1'b0;
    rq = 19'h4_0221;
    for (int k = 0; k < 3; k++)
    begin
      take(got);
      rq[o[k]] = 1'b0;
      chk(got, {12'(o[k]+1), 5'(o[k]+2)});
    end
    cyc(3);
    chk(vec.valid, 1'b0);
    global_enable = 1'b0;
    enable[0] = 1'b1;
    cyc(3);
    chk(vec.valid, 1'b0);
    global_enable = 1'b1;
    take(got);
    rq = 19'h0;
    chk(got, {12'h001, 5'h02});
  endtask
  task automatic s_select;
    logic [16:0] got;
    lag = 2'h0;
    wrc(8'h01);
    chk(vector_change_enable, 1'b1);
    wrc(8'h02);
    chk(vector_table_select, 1'b1);
    chk(vector_change_enable, 1'b0);
    rq = 19'h4_0000;
    take(got);
    rq = 19'h0;
    chk(got, {BRA + 12'h013, 5'h14});
    wrc(8'h00);
    chk(vector_table_select, 1'b1);
    wrc(8'h01);
    cyc(3);
    chk(vector_change_enable, 1'b1);
    wrc(8'h00);
    chk(vector_table_select, 1'b1);
    chk(vector_change_enable, 1'b0);
    wrc(8'h01);
    cyc(2);
    wrc(8'h00);
    chk(vector_table_select, 1'b0);
  endtask
  initial
  begin
    s_reset();
    s_table();
    s_prio();
    s_select();
    results();
  end
endmodule
bind rivp_top rivp_checker #(
  .BOOT_RESET_ADDR(BOOT_RESET_ADDR)
) u_chk (
  .sys_clk              (sys_clk),
  .rstn                 (rstn),
  .boot_reset_fuse      (boot_reset_fuse),
  .req                  (req),
  .enable               (enable),
  .global_enable        (global_enable),
  .ctrl_wr              (ctrl_wr),
  .ctrl_wdata           (ctrl_wdata),
  .vec_ack              (vec_ack),
  .reset_addr           (reset_addr),
  .vec                  (vec),
  .vector_table_select  (vector_table_select),
  .vector_change_enable (vector_change_enable)
);

// *** test/rivp_checker.sv ***
`timescale 1ns/10ps
module rivp_checker #(
  parameter logic [11:0] BOOT_RESET_ADDR = 12'h0C00
) (
  input wire logic                sys_clk,
  input wire logic                rstn,
  input wire logic                boot_reset_fuse,
  input wire rivp_pkg::rivp_req_t req,
  input wire logic [18:0]         enable,
  input wire logic                global_enable,
  input wire logic                ctrl_wr,
  input wire logic [7:0]          ctrl_wdata,
  input wire logic                vec_ack,
  input wire logic [11:0]         reset_addr,
  input wire rivp_pkg::rivp_vec_t vec,
  input wire logic                vector_table_select,
  input wire logic                vector_change_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_armed_quiet;
    $rose(vector_change_enable) ##0 (!ctrl_wr) [*4];
  endsequence
  a_reset_place: assert property ($past(rstn) |->
    reset_addr == (boot_reset_fuse ? 12'h000 : BOOT_RESET_ADDR)) else $error("reset addr");
  a_vec_place: assert property (vec.valid |-> vec.addr ==
    (vector_table_select ? BOOT_RESET_ADDR : 12'h000) + 12'(vec.number) - 12'h001)
    else $error("vec addr");
  a_vec_range: assert property (vec.valid |-> vec.number inside {[5'h02:5'h14]})
    else $error("vec number");
  a_vec_hold: assert property (vec.valid && !vec_ack |=> $stable(vec))
    else $error("vec hold");
  a_vec_answer: assert property (!vec.valid && global_enable && |(req & enable)
    |=> vec.valid) else $error("no dispatch");
  a_gate_off: assert property (!global_enable && !vec.valid |=> !vec.valid)
    else $error("gated dispatch");
  a_window_close: assert property (s_armed_quiet |=> !vector_change_enable)
    else $error("window open");
  a_change_arm: assert property (ctrl_wr && ctrl_wdata[0] |=> vector_change_enable)
    else $error("change enable");
  a_select_guard: assert property ($changed(vector_table_select) |->
    $past(vector_change_enable) && $past(ctrl_wr) && !$past(ctrl_wdata[0]))
    else $error("select change");
endmodule

// *** test/rivp_core_model.sv ***
`timescale 1ns/10ps
module rivp_core_model (
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire rivp_pkg::rivp_vec_t vec,
  input  wire logic [1:0]          lag,
  output logic                     vec_ack
);
  logic [1:0] wait_r;
  // fetches only offered vectors, after lag cycles, never twice in a row
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !vec.valid || vec_ack)
    begin
      vec_ack <= 1'b0;
      wait_r  <= 2'h0;
    end
    else if (wait_r == lag)
    begin
      vec_ack <= 1'b1;
    end
    else
    begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule
